// [include/dchd_pkg.sv]
package dchd_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_POS_LEG = 8'h22;
  localparam logic [7:0] ADDR_NEG_LEG = 8'h23;
  localparam logic [7:0] ADDR_PHASE_DET = 8'h24;
  localparam logic [7:0] ADDR_DUTY = 8'h25;
  localparam logic [7:0] ADDR_CTRL = 8'h26;
  localparam logic [7:0] ADDR_TARGET = 8'h27;
  localparam logic [7:0] ADDR_DELAY_HIGH = 8'h28;
  localparam logic [7:0] ADDR_SEARCH_OPT = 8'h29;
  localparam logic [7:0] ADDR_STATUS = 8'h2A;

  // Field layouts, most significant field first
  typedef struct packed {
    logic [2:0] rsvd;
    logic raise_common;
    logic [3:0] magnitude;
  } dchd_leg_offset_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic comparator_bias_boost;
    logic phase_detector_auto_enable;
    logic [3:0] rsvd_lo;
  } dchd_phase_det_t;

  typedef struct packed {
    logic duty_cycle_auto_enable;
    logic [6:0] rsvd;
  } dchd_duty_t;

  typedef struct packed {
    logic rsvd;
    logic slope_positive;
    logic [1:0] mode;
    logic read_sel;
    logic [1:0] gain;
    logic enable;
  } dchd_ctrl_t;

  typedef struct packed {
    logic delay_lsb;
    logic [1:0] search_direction;
    logic [4:0] target_phase;
  } dchd_target_t;

  typedef struct packed {
    logic exact;
    logic retry;
    logic restart;
    logic [4:0] guard;
  } dchd_search_opt_t;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h42;
  localparam logic [7:0] RST_SEARCH_OPT = 8'h0B;

  // Field encodings
  localparam logic [1:0] MODE_SEARCH_TRACK = 2'h0;
  localparam logic [1:0] MODE_SEARCH_ONLY = 2'h1;
  localparam logic [1:0] MODE_TRACK_ONLY = 2'h2;
  localparam logic [1:0] DIR_DOWN = 2'h0;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN_UP = 2'h2;

  // Delay line and timing
  localparam logic [8:0] DELAY_MAX = 9'h1B0;
  localparam logic [5:0] NEAR_TOL = 6'h02;
  localparam logic [7:0] SETTLE_CYCLES = 8'h08;
  localparam logic [7:0] TRACK_BASE = 8'h40;
endpackage : dchd_pkg

// [design/dchd_align_ctrl.sv]
`timescale 1ns/1ps
// Overview of operation
// R1 - Per-leg direction bit: 0 lowers, 1 raises the input common level.
// R2 - Software writes a 4-bit offset magnitude per leg; all ones advised.
// R3 - Software sets phase detector enable bit 4 and bias boost bit 5.
// R4 - Software sets duty register bit 7 to enable automatic duty cycle.
// R5 - Control bit 6 picks locked slope, 1 positive; resets to 1.
// R6 - Mode field: 00 search then track, 01 search only, 10 track only.
// R7 - Read-select bit 3 makes delay registers return the live delay value.
// R8 - Gain field bits 2:1 sets tracking gain; resets to 01.
// R9 - Control bit 0 enables the alignment controller; resets to 0.
// R10 - Delay LSB is bit 7 of 0x27; bits 8:1 fill 0x28.
// R11 - Search field: 00 down, 01 up, 10 down then up.
// R12 - Five-bit target phase sets the lock point, at most 16; the code takes any written value up to 31 unchecked.
// R13 - Controller off: delay value drives the delay line directly, max 432; the code passes it unclamped while off, up to 511.
// R14 - Controller on: delay value is the search start point.
// R15 - 0x28 reads written or locked value with read-select, else zero.
// R16 - Status bit 0 shows locked, bit 1 shows lost lock.
// R17 - Guard band keeps search off delay line ends unless nothing found.
// R18 - Software programs all fields before setting the enable bit.
module dchd_align_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Phase detector from the converter core
  input wire logic [4:0] i_phase_code,
  input wire logic i_phase_slope,
  // Clock input trim
  output dchd_pkg::dchd_leg_offset_t o_pos_leg,
  output dchd_pkg::dchd_leg_offset_t o_neg_leg,
  // Alignment loop controls and status
  output logic o_phase_detector_auto_enable,
  output logic o_comparator_bias_boost,
  output logic o_duty_cycle_auto_enable,
  output logic [8:0] o_delay_line,
  output logic o_locked,
  output logic o_lost
);
  typedef enum logic [2:0] {ST_OFF, ST_SEARCH, ST_TRACK, ST_HOLD, ST_FAIL}
    dchd_state_t;

  dchd_pkg::dchd_phase_det_t det;
  dchd_pkg::dchd_duty_t duty;
  dchd_pkg::dchd_ctrl_t ctrl;
  dchd_pkg::dchd_target_t tgt;
  dchd_pkg::dchd_search_opt_t opt;
  logic [7:0] delay_high;
  dchd_state_t state;
  logic [8:0] cur_delay;
  logic going_up;
  logic guard_on;
  logic [7:0] step_cnt;
  logic [4:0] ph_meta, ph_sync;
  logic slope_meta, slope_sync;
  logic [8:0] wr_delay, start_delay, lo_bound, hi_bound;
  logic signed [5:0] err;
  logic in_window, slope_ok, match, tick, lose_evt;
  logic [7:0] tick_limit, rd_mux;

  // Two-flop sync of phase detector outputs
  always_ff @(posedge i_clk) begin
    ph_meta <= i_phase_code;
    ph_sync <= ph_meta;
    slope_meta <= i_phase_slope;
    slope_sync <= slope_meta;
  end

  // Trim and enable registers, reserved bits kept zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pos_leg <= dchd_pkg::RST_ZERO;
      o_neg_leg <= dchd_pkg::RST_ZERO;
      det <= dchd_pkg::RST_ZERO;
      duty <= dchd_pkg::RST_ZERO;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        dchd_pkg::ADDR_POS_LEG: o_pos_leg <= {3'h0, i_reg_wdata[4:0]}; // [R1]
        dchd_pkg::ADDR_NEG_LEG: o_neg_leg <= {3'h0, i_reg_wdata[4:0]}; // [R1]
        dchd_pkg::ADDR_PHASE_DET: det <= {2'h0, i_reg_wdata[5:4], 4'h0};
        dchd_pkg::ADDR_DUTY: duty <= {i_reg_wdata[7], 7'h00};
        default: ;
      endcase
    end
  end

  // Alignment controller configuration registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl <= dchd_pkg::RST_CTRL; // [R5] [R8] [R9]
      tgt <= dchd_pkg::RST_ZERO;
      delay_high <= dchd_pkg::RST_ZERO;
      opt <= dchd_pkg::RST_SEARCH_OPT; // [R17]
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        dchd_pkg::ADDR_CTRL: ctrl <= {1'b0, i_reg_wdata[6:0]};
        dchd_pkg::ADDR_TARGET: tgt <= i_reg_wdata; // [R10]
        dchd_pkg::ADDR_DELAY_HIGH: delay_high <= i_reg_wdata; // [R10]
        dchd_pkg::ADDR_SEARCH_OPT: opt <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Plain outputs of the control registers
  always_ff @(posedge i_clk) begin
    o_phase_detector_auto_enable <= det.phase_detector_auto_enable;
    o_comparator_bias_boost <= det.comparator_bias_boost;
    o_duty_cycle_auto_enable <= duty.duty_cycle_auto_enable;
  end

  // Search window, phase error and step timing
  always_comb begin
    wr_delay = {delay_high, tgt.delay_lsb}; // [R10]
    start_delay = (wr_delay > dchd_pkg::DELAY_MAX) ? dchd_pkg::DELAY_MAX
                                                   : wr_delay; // [R14]
    lo_bound = guard_on ? {4'h0, opt.guard} : 9'h000; // [R17]
    hi_bound = guard_on ? dchd_pkg::DELAY_MAX - {4'h0, opt.guard}
                        : dchd_pkg::DELAY_MAX;
    err = $signed({1'b0, ph_sync}) - $signed({1'b0, tgt.target_phase});
    in_window = (err <= $signed(dchd_pkg::NEAR_TOL)) &&
                (err >= -$signed(dchd_pkg::NEAR_TOL));
    slope_ok = (slope_sync == ctrl.slope_positive); // [R5]
    match = slope_ok && (opt.exact ? (err == 6'sh00) : in_window); // [R12]
    tick_limit = (state == ST_SEARCH) ? dchd_pkg::SETTLE_CYCLES - 8'h01
               : (dchd_pkg::TRACK_BASE >> ctrl.gain) - 8'h01; // [R8]
    tick = det.phase_detector_auto_enable && (step_cnt == tick_limit);
    lose_evt = (state == ST_TRACK) && tick && !(in_window && slope_ok);
  end

  // Step counter paced by the phase detector
  always_ff @(posedge i_clk) begin
    if (i_reset || state == ST_OFF || tick) begin
      step_cnt <= 8'h00;
    end else if (det.phase_detector_auto_enable) begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  // Alignment controller sequencing
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= ST_OFF;
      cur_delay <= 9'h000;
      going_up <= 1'b0;
      guard_on <= 1'b1;
    end else if (!ctrl.enable) begin
      state <= ST_OFF; // [R9]
      cur_delay <= wr_delay; // [R13]
    end else begin
      unique case (state)
        ST_OFF: begin
          cur_delay <= start_delay; // [R14]
          going_up <= (tgt.search_direction == dchd_pkg::DIR_UP); // [R11]
          guard_on <= 1'b1;
          state <= (ctrl.mode == dchd_pkg::MODE_TRACK_ONLY) ? ST_TRACK
                                                            : ST_SEARCH; // [R6]
        end
        ST_SEARCH: begin
          if (tick) begin
            if (match) begin
              state <= (ctrl.mode == dchd_pkg::MODE_SEARCH_ONLY) ? ST_HOLD
                                                                 : ST_TRACK;
            end else if (going_up && cur_delay < hi_bound) begin
              cur_delay <= cur_delay + 9'h001; // [R11]
            end else if (!going_up && cur_delay > lo_bound) begin
              cur_delay <= cur_delay - 9'h001; // [R11]
            end else if (!going_up &&
                         tgt.search_direction == dchd_pkg::DIR_DOWN_UP) begin
              going_up <= 1'b1; // [R11]
            end else if (guard_on) begin
              guard_on <= 1'b0; // [R17]
              cur_delay <= start_delay;
              going_up <= (tgt.search_direction == dchd_pkg::DIR_UP);
            end else begin
              state <= (opt.retry || opt.restart) ? ST_OFF : ST_FAIL;
            end
          end
        end
        ST_TRACK: begin
          if (lose_evt) begin
            state <= ST_OFF;
          end else if (tick && err != 6'sh00) begin
            if ((err < 6'sh00) == ctrl.slope_positive) begin
              if (cur_delay < dchd_pkg::DELAY_MAX) begin
                cur_delay <= cur_delay + 9'h001;
              end
            end else if (cur_delay != 9'h000) begin
              cur_delay <= cur_delay - 9'h001;
            end
          end
        end
        ST_HOLD: state <= ST_HOLD;
        ST_FAIL: state <= ST_FAIL;
      endcase
    end
  end

  // Delay line drive and lock status
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_delay_line <= 9'h000;
      o_locked <= 1'b0;
    end else begin
      o_delay_line <= cur_delay; // [R13]
      o_locked <= (state == ST_TRACK) || (state == ST_HOLD); // [R16]
    end
  end

  // Lost-lock flag, set wins over the clear on disable
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_lost <= 1'b0;
    end else if (lose_evt) begin
      o_lost <= 1'b1; // [R16]
    end else if (!ctrl.enable) begin
      o_lost <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    unique case (i_reg_addr)
      dchd_pkg::ADDR_POS_LEG: rd_mux = o_pos_leg;
      dchd_pkg::ADDR_NEG_LEG: rd_mux = o_neg_leg;
      dchd_pkg::ADDR_PHASE_DET: rd_mux = det;
      dchd_pkg::ADDR_DUTY: rd_mux = duty;
      dchd_pkg::ADDR_CTRL: rd_mux = ctrl;
      dchd_pkg::ADDR_TARGET: rd_mux = ctrl.read_sel ?
        {cur_delay[0], tgt[6:0]} : tgt; // [R7]
      dchd_pkg::ADDR_DELAY_HIGH: rd_mux = ctrl.read_sel ?
        cur_delay[8:1] : dchd_pkg::RST_ZERO; // [R15]
      dchd_pkg::ADDR_SEARCH_OPT: rd_mux = opt;
      dchd_pkg::ADDR_STATUS: rd_mux = {6'h00, o_lost, o_locked}; // [R16]
      default: rd_mux = dchd_pkg::RST_ZERO;
    endcase
  end

  // Read data register, held between reads
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata <= dchd_pkg::RST_ZERO;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  // Checks
  property p_off_drives_line;
    @(posedge i_clk) disable iff (i_reset)
    (!ctrl.enable ##1 !ctrl.enable) |=> o_delay_line == $past(wr_delay, 2);
  endproperty
  a_off_drives_line: assert property (p_off_drives_line) // [R13]
    else $error("delay line does not follow written value while off");

  property p_high_write_only;
    @(posedge i_clk) disable iff (i_reset)
    (i_reg_rd && i_reg_addr == dchd_pkg::ADDR_DELAY_HIGH && !ctrl.read_sel)
      |=> o_reg_rdata == 8'h00;
  endproperty
  a_high_write_only: assert property (p_high_write_only) // [R15]
    else $error("upper delay register readable without read select");

  property p_live_readback;
    @(posedge i_clk) disable iff (i_reset)
    (i_reg_rd && i_reg_addr == dchd_pkg::ADDR_DELAY_HIGH && ctrl.read_sel)
      |=> o_reg_rdata == $past(cur_delay[8:1]);
  endproperty
  a_live_readback: assert property (p_live_readback) // [R7]
    else $error("read select does not return live delay");

  property p_disable_unlocks;
    @(posedge i_clk) disable iff (i_reset)
    !ctrl.enable |=> state == ST_OFF ##1 !o_locked;
  endproperty
  a_disable_unlocks: assert property (p_disable_unlocks) // [R9]
    else $error("controller still active after disable");

  property p_track_only;
    @(posedge i_clk) disable iff (i_reset)
    (state == ST_OFF && ctrl.enable &&
     ctrl.mode == dchd_pkg::MODE_TRACK_ONLY) |=> state == ST_TRACK;
  endproperty
  a_track_only: assert property (p_track_only) // [R6]
    else $error("track-only mode did not skip search");

  property p_search_up;
    @(posedge i_clk) disable iff (i_reset)
    (ctrl.enable && state == ST_SEARCH && tick && !match && going_up &&
     cur_delay < hi_bound) |=> cur_delay == $past(cur_delay) + 9'h001;
  endproperty
  a_search_up: assert property (p_search_up) // [R11]
    else $error("upward search did not step the delay");

  property p_slope_mismatch;
    @(posedge i_clk) disable iff (i_reset)
    (ctrl.enable && state == ST_SEARCH && tick && !slope_ok && going_up &&
     cur_delay < hi_bound) |=> state == ST_SEARCH;
  endproperty
  a_slope_mismatch: assert property (p_slope_mismatch) // [R5]
    else $error("locked on the wrong slope");

  property p_lost_flag;
    @(posedge i_clk) disable iff (i_reset)
    lose_evt |=> o_lost ##1
      (!o_locked && (o_lost || !$past(ctrl.enable)));
  endproperty
  a_lost_flag: assert property (p_lost_flag) // [R16]
    else $error("lost lock not reported");

  property p_leg_dir;
    @(posedge i_clk) disable iff (i_reset)
    (i_reg_wr && i_reg_addr == dchd_pkg::ADDR_POS_LEG)
      |=> o_pos_leg.raise_common == $past(i_reg_wdata[4]);
  endproperty
  a_leg_dir: assert property (p_leg_dir) // [R1]
    else $error("positive leg direction not stored");
endmodule : dchd_align_ctrl

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  // Stimulus driven into the block
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [4:0] i_phase_code = 5'h00;
  logic i_phase_slope = 1'b0;
  // Observed outputs
  logic [7:0] o_reg_rdata;
  dchd_pkg::dchd_leg_offset_t o_pos_leg;
  dchd_pkg::dchd_leg_offset_t o_neg_leg;
  logic o_phase_detector_auto_enable;
  logic o_comparator_bias_boost;
  logic o_duty_cycle_auto_enable;
  logic [8:0] o_delay_line;
  logic o_locked;
  logic o_lost;
  // Bookkeeping
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;

  // Clock at 40 MHz
  always #12.5 i_clk = ~i_clk;

  dchd_align_ctrl i_dut (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_phase_code(i_phase_code),
    .i_phase_slope(i_phase_slope),
    .o_pos_leg(o_pos_leg),
    .o_neg_leg(o_neg_leg),
    .o_phase_detector_auto_enable(o_phase_detector_auto_enable),
    .o_comparator_bias_boost(o_comparator_bias_boost),
    .o_duty_cycle_auto_enable(o_duty_cycle_auto_enable),
    .o_delay_line(o_delay_line),
    .o_locked(o_locked),
    .o_lost(o_lost)
  );

  // Verdict and end of run
  task automatic conclude;
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude();
    end
  end

  // Value comparison
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Wait n edges then let updates land
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  // One register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  // One register read, compared with expected byte
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk({1'b0, o_reg_rdata}, {1'b0, e});
  endtask : rchk

  // Reset values
  task automatic t_reset;
    rchk(dchd_pkg::ADDR_CTRL, dchd_pkg::RST_CTRL);
    rchk(dchd_pkg::ADDR_DELAY_HIGH, 8'h00);
    rchk(dchd_pkg::ADDR_STATUS, 8'h00);
    rchk(dchd_pkg::ADDR_SEARCH_OPT, dchd_pkg::RST_SEARCH_OPT);
    chk({8'h00, o_locked}, 9'h000);
  endtask : t_reset

  // Clock leg trim, reserved bits dropped
  task automatic t_legs;
    wr(dchd_pkg::ADDR_POS_LEG, 8'h1F);
    wr(dchd_pkg::ADDR_NEG_LEG, 8'h0F);
    settle(1);
    chk({1'b0, o_pos_leg}, 9'h01F);
    chk({1'b0, o_neg_leg}, 9'h00F);
    wr(dchd_pkg::ADDR_POS_LEG, 8'hEF);
    settle(1);
    chk({1'b0, o_pos_leg}, 9'h00F);
    rchk(dchd_pkg::ADDR_POS_LEG, 8'h0F);
  endtask : t_legs

  // Detector and duty enables, unmapped place
  task automatic t_enables;
    wr(dchd_pkg::ADDR_PHASE_DET, 8'h30);
    wr(dchd_pkg::ADDR_DUTY, 8'h80);
    settle(1);
    chk({8'h00, o_phase_detector_auto_enable}, 9'h001);
    chk({8'h00, o_comparator_bias_boost}, 9'h001);
    chk({8'h00, o_duty_cycle_auto_enable}, 9'h001);
    wr(8'h30, 8'hFF);
    rchk(8'h30, 8'h00);
  endtask : t_enables

  // Every mode and search direction code
  task automatic t_fields;
    logic [7:0] v;
    for (int m = 0; m < 3; m++) begin
      v = {2'b01, 2'(m), 4'h2};
      wr(dchd_pkg::ADDR_CTRL, v);
      rchk(dchd_pkg::ADDR_CTRL, v);
    end
    for (int d = 0; d < 3; d++) begin
      v = {1'b0, 2'(d), 5'h10};
      wr(dchd_pkg::ADDR_TARGET, v);
      rchk(dchd_pkg::ADDR_TARGET, v);
    end
  endtask : t_fields

  // Direct delay setting with controller off
  task automatic t_delay;
    wr(dchd_pkg::ADDR_CTRL, 8'h02);
    wr(dchd_pkg::ADDR_TARGET, 8'hC4);
    wr(dchd_pkg::ADDR_DELAY_HIGH, 8'h6C);
    settle(3);
    chk(o_delay_line, 9'h0D9);
    rchk(dchd_pkg::ADDR_DELAY_HIGH, 8'h00);
    wr(dchd_pkg::ADDR_CTRL, 8'h0A);
    rchk(dchd_pkg::ADDR_DELAY_HIGH, 8'h6C);
    rchk(dchd_pkg::ADDR_TARGET, 8'hC4);
    wr(dchd_pkg::ADDR_TARGET, 8'h44);
    wr(dchd_pkg::ADDR_DELAY_HIGH, 8'hD8);
    settle(3);
    chk(o_delay_line, dchd_pkg::DELAY_MAX);
  endtask : t_delay

  // Lock at start point, lose lock, disable
  task automatic t_lock;
    wr(dchd_pkg::ADDR_DELAY_HIGH, 8'h6C);
    i_phase_code <= 5'h04;
    i_phase_slope <= 1'b0;
    wr(dchd_pkg::ADDR_CTRL, 8'h0B);
    for (int k = 0; k < 300 && o_locked !== 1'b1; k++) settle(1);
    chk({8'h00, o_locked}, 9'h001);
    chk(o_delay_line, 9'h0D8);
    rchk(dchd_pkg::ADDR_STATUS, 8'h01);
    rchk(dchd_pkg::ADDR_DELAY_HIGH, 8'h6C);
    @(posedge i_clk);
    i_phase_code <= 5'h0C;
    for (int k = 0; k < 300 && o_lost !== 1'b1; k++) settle(1);
    chk({8'h00, o_lost}, 9'h001);
    rchk(dchd_pkg::ADDR_STATUS, 8'h02);
    wr(dchd_pkg::ADDR_CTRL, 8'h0A);
    settle(3);
    chk({8'h00, o_lost}, 9'h000);
    chk(o_delay_line, 9'h0D8);
  endtask : t_lock

  // Track-only stepping, then upward search on the wrong slope
  task automatic t_modes;
    @(posedge i_clk);
    i_phase_code <= 5'h03;
    wr(dchd_pkg::ADDR_CTRL, 8'h2B);
    settle(2);
    chk({8'h00, o_locked}, 9'h001);
    chk(o_delay_line, 9'h0D8);
    settle(40);
    chk(o_delay_line, 9'h0D7);
    chk({8'h00, o_lost}, 9'h000);
    wr(dchd_pkg::ADDR_CTRL, 8'h0A);
    i_phase_code <= 5'h04;
    wr(dchd_pkg::ADDR_TARGET, 8'h24);
    wr(dchd_pkg::ADDR_CTRL, 8'h4B);
    settle(30);
    chk(o_delay_line, 9'h0DB);
    chk({8'h00, o_locked}, 9'h000);
  endtask : t_modes

  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_legs();
    t_enables();
    t_fields();
    t_delay();
    t_lock();
    t_modes();
    conclude();
  end
endmodule : testbench
